//--- rtl/bbp_brightness_pwm.sv
// Brightness path: input duty measurement, sloper, dither and phase-shifted LED PWM outputs.
//
// Overview of operation
// - In direct mode every active channel simply follows the input PWM pin.
// - After reset the sloper runs with smoothing on and a 200 ms transition time.
// - A three-bit slope code picks the transition time, and code zero applies changes at once.
// - The smoothing bit adds an easing on top of the linear slope so changes look softer.
// - With the pin as source outside direct mode, the held duty only moves when the change exceeds 0.19 percent.
// - Without dither one brightness step is one 20 MHz oscillator tick at the reset period setting, two at the longest period and half per shorter one.
// - A four-bit dither field selects off or 1 to 4 extra bits, and it is off after reset.
// - With 1-bit dither every second pulse may be one tick longer.
// - With 3-bit dither the dither value sets how many of each 8 pulses are one tick longer.
// - Pulses shorter than 200 ns are skipped and accumulated so average brightness keeps falling.
// - Skipping never lets the pulse rate fall below 152 Hz.
// - A source select picks the measured pin duty or the register brightness, the pin after reset.
// - The LED period comes from the oscillator alone, one of eight values from 152 Hz to 19.531 kHz.
// - In phase-shift mode active channels are spaced evenly by period over channel count.
//
// Our own choices: register access over AHB-Lite and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module bbp_brightness_pwm (
  // Clock, reset and enable
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Brightness input and LED channels
  input wire logic pwm_in,
  output logic [5:0] led_pwm
);
  logic [15:0] ctrl;
  logic [15:0] register_brightness_value;
  logic wr_pend;
  logic [7:0] wr_addr;
  logic [15:0] bright;
  logic [15:0] duty_held;
  logic [15:0] target;
  logic [15:0] last_target;
  logic [15:0] base_step;

  wire logic brightness_source_select = ctrl[bbp_pkg::CTRL_SRC];
  wire logic smooth_curve_enable = ctrl[bbp_pkg::CTRL_SMOOTH];
  wire logic [2:0] slope_code = ctrl[bbp_pkg::CTRL_SLOPE_LSB +: 3];
  wire logic [3:0] dither_raw = ctrl[bbp_pkg::CTRL_DITHER_LSB +: 4];
  wire logic [2:0] dimming_freq_resistor = ctrl[bbp_pkg::CTRL_FSEL_LSB +: 3];
  wire logic [2:0] nch_raw = ctrl[bbp_pkg::CTRL_NCH_LSB +: 3];
  wire logic direct_mode = ctrl[bbp_pkg::CTRL_DIRECT];

  // The slave never stretches a transfer, so every answer is OKAY with no wait state.
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  wire logic addr_ok = hsel && hready && htrans[1] && ce;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
    end
    else if (ce)
    begin
      wr_pend <= addr_ok && hwrite;
      wr_addr <= haddr[7:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ctrl <= bbp_pkg::CTRL_RESET;
      register_brightness_value <= bbp_pkg::BRT_RESET;
    end
    else if (ce && wr_pend)
    begin
      if (wr_addr == bbp_pkg::ADDR_CTRL)
        ctrl <= hwdata[15:0];
      else if (wr_addr == bbp_pkg::ADDR_BRT)
        register_brightness_value <= hwdata[15:0];
    end
  end

  // Read data is captured in the address phase, so it stands for the whole data phase.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hrdata <= 32'h00000000;
    else if (addr_ok && !hwrite)
    begin
      case (haddr[7:0])
        bbp_pkg::ADDR_CTRL: hrdata <= {16'h0000, ctrl};
        bbp_pkg::ADDR_BRT: hrdata <= {16'h0000, register_brightness_value};
        bbp_pkg::ADDR_STAT: hrdata <= {target, bright};
        bbp_pkg::ADDR_DUTY: hrdata <= {16'h0000, duty_held};
        default: hrdata <= 32'h00000000;
      endcase
    end
  end

  // Input duty measurement; inputs are synchronous, so no synchroniser is needed.
  bbp_pkg::bbp_meas_t ms_state;
  logic pwm_prev;
  logic [23:0] per_cnt;
  logic [23:0] high_cnt;
  logic [23:0] div_per;
  logic [24:0] div_rem;
  logic [15:0] div_q;
  logic [3:0] div_idx;
  wire logic [24:0] div_shift = {div_rem[23:0], 1'b0};
  wire logic div_ge = div_shift >= {1'b0, div_per};
  wire logic rise = pwm_in && !pwm_prev;
  wire logic fall = !pwm_in && pwm_prev;
  wire logic div_done = (ms_state == bbp_pkg::BBP_MS_DIV) && (div_idx == bbp_pkg::DIV_LAST);
  wire logic [15:0] div_result = {div_q[14:0], div_ge};
  wire logic stuck = per_cnt == bbp_pkg::MEAS_SAT;
  logic [15:0] new_duty;
  logic [15:0] duty_diff;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      pwm_prev <= 1'b0;
      per_cnt <= 24'h000000;
      high_cnt <= 24'h000000;
    end
    else if (ce)
    begin
      pwm_prev <= pwm_in;
      if (rise)
        per_cnt <= 24'h000001;
      else if (!stuck)
        per_cnt <= per_cnt + 24'h000001;
      if (fall)
        high_cnt <= per_cnt;
    end
  end

  // A sequential divider turns high time over period into a 16-bit duty.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ms_state <= bbp_pkg::BBP_MS_IDLE;
      div_per <= 24'h000000;
      div_rem <= 25'h0000000;
      div_q <= 16'h0000;
      div_idx <= 4'h0;
    end
    else if (ce)
    begin
      case (ms_state)
        bbp_pkg::BBP_MS_IDLE:
        begin
          if (rise && per_cnt != 24'h000000 && !stuck)
          begin
            div_per <= per_cnt;
            div_rem <= {1'b0, high_cnt};
            div_idx <= 4'h0;
            ms_state <= bbp_pkg::BBP_MS_DIV;
          end
        end
        bbp_pkg::BBP_MS_DIV:
        begin
          div_rem <= div_ge ? div_shift - {1'b0, div_per} : div_shift;
          div_q <= div_result;
          div_idx <= div_idx + 4'h1;
          if (div_done)
            ms_state <= bbp_pkg::BBP_MS_IDLE;
        end
        default: ms_state <= bbp_pkg::BBP_MS_IDLE;
      endcase
    end
  end

  // A pin without edges reads as fully on or fully off.
  always_comb
  begin
    new_duty = stuck ? (pwm_prev ? bbp_pkg::DUTY_FULL : 16'h0000) : div_result;
    duty_diff = (new_duty > duty_held) ? new_duty - duty_held : duty_held - new_duty;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      duty_held <= 16'h0000;
    else if (ce && (div_done || stuck) && duty_diff > bbp_pkg::HYST_COUNTS)
      duty_held <= new_duty;
  end

  assign target = brightness_source_select ? register_brightness_value : duty_held;

  // Sloper timing and stepping.
  logic [9:0] sub_cnt;
  logic [8:0] ms_cnt;
  logic [15:0] remain;
  logic [15:0] step;
  wire logic [8:0] slope_ms = bbp_pkg::bbp_slope_ms(slope_code);
  wire logic slope_tick = (sub_cnt == bbp_pkg::SLOPE_SUB_LAST) && (ms_cnt + 9'h001 >= slope_ms);

  always_comb
  begin
    remain = (target > bright) ? target - bright : bright - target;
    step = base_step;
    if (smooth_curve_enable && (remain >> 3) < base_step)
      step = ((remain >> 3) == 16'h0000) ? 16'h0001 : remain >> 3;
    if (step > remain)
      step = remain;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      sub_cnt <= 10'h000;
      ms_cnt <= 9'h000;
    end
    else if (ce)
    begin
      sub_cnt <= (sub_cnt == bbp_pkg::SLOPE_SUB_LAST) ? 10'h000 : sub_cnt + 10'h001;
      if (sub_cnt == bbp_pkg::SLOPE_SUB_LAST)
        ms_cnt <= slope_tick ? 9'h000 : ms_cnt + 9'h001;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      bright <= 16'h0000;
      last_target <= 16'h0000;
      base_step <= 16'h0001;
    end
    else if (ce)
    begin
      last_target <= target;
      if (slope_code == 3'h0)
        bright <= target;
      else if (target != last_target)
        base_step <= ((remain >> bbp_pkg::SLOPE_STEP_SHIFT) == 16'h0000) ? 16'h0001
                     : remain >> bbp_pkg::SLOPE_STEP_SHIFT;
      else if (slope_tick)
        bright <= (target > bright) ? bright + step : bright - step;
    end
  end

  // Oscillator tick: 250 MHz times 2/25 gives 20 MHz on average.
  logic [4:0] osc_acc;
  wire logic [4:0] osc_sum = osc_acc + bbp_pkg::OSC_NUM;
  wire logic osc_tick = osc_sum >= bbp_pkg::OSC_DEN;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      osc_acc <= 5'h00;
    else if (ce)
      osc_acc <= osc_tick ? osc_sum - bbp_pkg::OSC_DEN : osc_sum;
  end

  wire logic [17:0] period_len = bbp_pkg::PERIOD_MAX >> dimming_freq_resistor;
  wire logic [16:0] cnt_mask = 17'(period_len - 18'h00001);
  logic [16:0] pcnt;
  logic [3:0] per_idx;
  logic [16:0] cur_width;
  logic [20:0] skip_acc;
  logic [17:0] gap_cnt;
  wire logic period_end = osc_tick && (pcnt == cnt_mask);

  wire logic [20:0] ext = {bright, 5'h00} >> dimming_freq_resistor;
  wire logic [16:0] width_base = ext[20:4];
  wire logic [3:0] dith = (dither_raw > bbp_pkg::DITHER_MAX) ? bbp_pkg::DITHER_MAX : dither_raw;
  wire logic [3:0] dmask = 4'(8'hf0 >> dith);
  wire logic [3:0] dval = ext[3:0] >> (4'h4 - dith);
  wire logic [3:0] rev_idx = {per_idx[0], per_idx[1], per_idx[2], per_idx[3]} >> (4'h4 - dith);
  wire logic [20:0] fine = {width_base, ext[3:0] & dmask};
  wire logic [20:0] acc_sum = skip_acc + fine;
  wire logic [17:0] gap_lim = (18'h00001 << dimming_freq_resistor) - 18'h00001;
  wire logic lengthen = rev_idx < dval;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      pcnt <= 17'h00000;
      per_idx <= 4'h0;
      cur_width <= 17'h00000;
      skip_acc <= 21'h000000;
      gap_cnt <= 18'h00000;
    end
    else if (ce && osc_tick)
    begin
      pcnt <= (pcnt == cnt_mask) ? 17'h00000 : (pcnt + 17'h00001) & cnt_mask;
      if (period_end)
      begin
        per_idx <= per_idx + 4'h1;
        if (width_base >= bbp_pkg::MIN_WIDTH)
        begin
          cur_width <= width_base + {16'h0000, lengthen};
          skip_acc <= 21'h000000;
          gap_cnt <= 18'h00000;
        end
        else if (acc_sum >= bbp_pkg::MIN_FINE || (gap_cnt >= gap_lim && fine != 21'h000000))
        begin
          cur_width <= bbp_pkg::MIN_WIDTH;
          skip_acc <= (acc_sum >= bbp_pkg::MIN_FINE) ? acc_sum - bbp_pkg::MIN_FINE : 21'h000000;
          gap_cnt <= 18'h00000;
        end
        else
        begin
          cur_width <= 17'h00000;
          skip_acc <= acc_sum;
          gap_cnt <= gap_cnt + 18'h00001;
        end
      end
    end
  end

  // Channel outputs; the phase offset is recomputed from the live period and channel count.
  wire logic [2:0] nch = (nch_raw == 3'h0 || nch_raw > bbp_pkg::NCH_MAX) ? bbp_pkg::NCH_MAX : nch_raw;
  logic [5:0] next_led;

  genvar gi;
  generate
    for (gi = 0; gi < bbp_pkg::NCH; gi++)
    begin : g_ch
      wire logic [35:0] off_full = 36'(18'(gi) * bbp_pkg::bbp_recip(nch)) * 36'(period_len);
      wire logic [16:0] offset = off_full[32:16] & cnt_mask;
      wire logic [16:0] pos = (pcnt - offset) & cnt_mask;
      wire logic active = 3'(gi) < nch;
      assign next_led[gi] = active && (direct_mode ? pwm_in : (pos < cur_width));
    end
  endgenerate

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      led_pwm <= 6'h00;
    else if (ce)
      led_pwm <= next_led;
  end
endmodule : bbp_brightness_pwm
`default_nettype wire

//--- rtl/bbp_pkg.sv
// Constants, register map and timing figures of the backlight brightness PWM path.
package bbp_pkg;
  // Register byte addresses on the AHB-Lite slave.
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_BRT = 8'h04;
  localparam logic [7:0] ADDR_STAT = 8'h08;
  localparam logic [7:0] ADDR_DUTY = 8'h0c;
  // Control register field positions.
  localparam int CTRL_SRC = 0;
  localparam int CTRL_SMOOTH = 1;
  localparam int CTRL_SLOPE_LSB = 2;
  localparam int CTRL_DITHER_LSB = 5;
  localparam int CTRL_FSEL_LSB = 9;
  localparam int CTRL_NCH_LSB = 12;
  localparam int CTRL_DIRECT = 15;
  localparam logic [15:0] CTRL_RESET = 16'h6216;
  localparam logic [15:0] BRT_RESET = 16'h0000;
  // Clock figures: 250 MHz system clock, 20 MHz oscillator tick made by a 2/25 phase accumulator.
  localparam int CLK_PERIOD_PS = 4000;
  localparam logic [4:0] OSC_NUM = 5'h02;
  localparam logic [4:0] OSC_DEN = 5'h19;
  localparam int OSC_PERIOD_NS = 50;
  localparam int MIN_PULSE_NS = 200;
  localparam int MIN_PULSE_TICKS = (MIN_PULSE_NS + OSC_PERIOD_NS - 1) / OSC_PERIOD_NS;
  localparam logic [20:0] MIN_FINE = 21'(MIN_PULSE_TICKS * 16);
  localparam logic [16:0] MIN_WIDTH = 17'(MIN_PULSE_TICKS);
  // Slope timing: the base step is 1/256 of the change, at least one count; one step waits slope_ms sub-intervals of 1/256 ms.
  localparam int SLOPE_SUB_NS = 3906;
  localparam int SLOPE_SUB_CYCLES = SLOPE_SUB_NS * 1000 / CLK_PERIOD_PS;
  localparam logic [9:0] SLOPE_SUB_LAST = 10'(SLOPE_SUB_CYCLES - 1);
  localparam int SLOPE_STEP_SHIFT = 8;
  // Duty hysteresis of 0.19 percent of full scale.
  localparam logic [15:0] HYST_COUNTS = 16'(65536 * 19 / 10000);
  // Longest LED period is 2^17 oscillator ticks, about 152 Hz.
  localparam logic [17:0] PERIOD_MAX = 18'h20000;
  localparam int NCH = 6;
  localparam logic [2:0] NCH_MAX = 3'h6;
  localparam logic [3:0] DITHER_MAX = 4'h4;
  localparam logic [23:0] MEAS_SAT = 24'hffffff;
  localparam logic [3:0] DIV_LAST = 4'hf;
  localparam logic [15:0] DUTY_FULL = 16'hffff;

  typedef enum logic [0:0] {
    BBP_MS_IDLE = 1'b0,
    BBP_MS_DIV = 1'b1
  } bbp_meas_t;

  // Transition time in ms for each slope code; code 0 bypasses the sloper.
  function automatic logic [8:0] bbp_slope_ms(input logic [2:0] code);
    case (code)
      3'h1: bbp_slope_ms = 9'h032;
      3'h2: bbp_slope_ms = 9'h04b;
      3'h3: bbp_slope_ms = 9'h064;
      3'h4: bbp_slope_ms = 9'h096;
      3'h5: bbp_slope_ms = 9'h0c8;
      3'h6: bbp_slope_ms = 9'h12c;
      3'h7: bbp_slope_ms = 9'h1f4;
      default: bbp_slope_ms = 9'h000;
    endcase
  endfunction : bbp_slope_ms

  // Fraction 65536/n of a period between neighbouring channels.
  function automatic logic [16:0] bbp_recip(input logic [2:0] n);
    case (n)
      3'h1: bbp_recip = 17'h10000;
      3'h2: bbp_recip = 17'h08000;
      3'h3: bbp_recip = 17'h05555;
      3'h4: bbp_recip = 17'h04000;
      3'h5: bbp_recip = 17'h03333;
      default: bbp_recip = 17'h02aaa;
    endcase
  endfunction : bbp_recip
endpackage : bbp_pkg

//--- tb/bbp_brightness_pwm_props.sv
// Port checker of the brightness PWM path.
`timescale 1ns/1ps
`default_nettype none
module bbp_brightness_pwm_props (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  // Bus
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  // Pins
  input wire logic pwm_in,
  input wire logic [5:0] led_pwm
);
  logic wr_ph;
  logic [7:0] wr_a;
  logic [15:0] ctrl_q;
  logic [23:0] gap0;
  logic [23:0] qt;
  logic [15:0] hi0;
  logic seen0;
  logic wr_c;
  logic dir;
  logic [23:0] per;
  logic [2:0] nch;
  logic [5:0] mask;
  assign wr_c = wr_ph && (wr_a == bbp_pkg::ADDR_CTRL);
  assign dir = ctrl_q[15];
  assign per = 24'((25 * (32'h20000 >> ctrl_q[11:9])) / 2);
  assign nch = (ctrl_q[14:12] == 3'h0 || ctrl_q[14:12] > 3'h6) ? 3'h6 : ctrl_q[14:12];
  assign mask = 6'h3f >> (3'h6 - nch);
  // Shadow of the control word, updated where the slave updates it.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_ph <= 1'b0;
      wr_a <= 8'h00;
      ctrl_q <= bbp_pkg::CTRL_RESET;
    end
    else if (ce)
    begin
      wr_ph <= hsel && hready && htrans[1] && hwrite;
      wr_a <= haddr[7:0];
      if (wr_c)
        ctrl_q <= hwdata[15:0];
    end
  end
  // The quiet timer qt restarts and seen0 clears on a control write, because old settings may finish their period.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      gap0 <= 24'h0;
      qt <= 24'h0;
      hi0 <= 16'h0;
      seen0 <= 1'b0;
    end
    else
    begin
      gap0 <= $rose(led_pwm[0]) ? 24'h1 : gap0 + {23'h0, gap0 != 24'hffffff};
      qt <= wr_c ? 24'h0 : qt + {23'h0, qt != 24'hffffff};
      hi0 <= led_pwm[0] ? hi0 + 16'h1 : 16'h0;
      seen0 <= !wr_c && !dir && (seen0 || $rose(led_pwm[0]));
    end
  end
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  AST_DIRECT_FOLLOW: assert property (dir && $past(dir) && $past(dir, 2) && $past(ce) |-> led_pwm[0] == $past(pwm_in))
    else $error("channel 0 does not follow the input pin");
  AST_DIRECT_ALL: assert property (dir && qt > 24'h2 |-> led_pwm == (led_pwm[0] ? mask : 6'h00))
    else $error("active channels differ in direct mode");
  AST_UNUSED_DARK: assert property (qt > 2 * per |-> (led_pwm & ~mask) == 6'h00)
    else $error("unused channel is lit");
  AST_PERIOD_MIN: assert property ($rose(led_pwm[0]) && seen0 |-> gap0 + 24'h10 >= per)
    else $error("LED period shorter than selected");
  AST_PULSE_MIN: assert property ($fell(led_pwm[0]) && seen0 |-> hi0 >= 16'h30)
    else $error("pulse shorter than minimum width");
  AST_PHASE_GAP: assert property ($rose(led_pwm[1]) && seen0 && nch > 3'h1 && gap0 < per
    |-> gap0 + 24'h18 >= per / nch && gap0 <= per / nch + 24'h18)
    else $error("channel 1 phase offset wrong");
  AST_BUS_OKAY: assert property (hsel |-> hreadyout && !hresp)
    else $error("slave response not ready and okay");
  AST_READ_HOLD: assert property (!$stable(hrdata) |-> $past(hsel && hready && htrans[1] && !hwrite))
    else $error("read data changed without a read");
  COV_DIRECT: cover property (dir && $rose(led_pwm[0]));
  COV_PHASE: cover property ($rose(led_pwm[1]) && seen0);
  COV_NARROW: cover property ($fell(led_pwm[0]) && seen0 && hi0 < 16'h40);
endmodule : bbp_brightness_pwm_props
bind bbp_brightness_pwm bbp_brightness_pwm_props bbp_brightness_pwm_props_i (.hclk(hclk), .hresetn(hresetn),
  .ce(ce), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready), .hwdata(hwdata),
  .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .pwm_in(pwm_in), .led_pwm(led_pwm));
`default_nettype wire

//--- tb/bbp_brightness_pwm_tb.sv
// Self-checking bench of the brightness PWM path.
`timescale 1ns/1ps
`default_nettype none
module bbp_brightness_pwm_tb;
  typedef struct packed {
    logic wr;
    logic [7:0] a;
    logic [31:0] d;
    logic [31:0] e;
  } bbp_row_t;
  logic hclk;
  logic hresetn;
  logic ce;
  logic hsel;
  logic [31:0] haddr;
  logic [1:0] htrans;
  logic hwrite;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic pwm_in;
  logic [5:0] led_pwm;
  logic run;
  logic [15:0] high_cyc;
  logic [31:0] rd;
  int n_errors;
  int n_tests;
  int hi;
  bbp_row_t rows [10];
  bbp_brightness_pwm bbp_brightness_pwm_i (.hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .pwm_in(pwm_in), .led_pwm(led_pwm));
  bbp_pwm_host bbp_pwm_host_i (.hclk(hclk), .hresetn(hresetn), .run(run), .high_cyc(high_cyc),
    .per_cyc(16'h0400), .pwm_in(pwm_in));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    n_tests++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  // One single word transfer; the master waits for ready in both phases.
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'b10;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hsel <= 1'b0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : bus
  task automatic width;
    hi = 0;
    while (led_pwm[0] !== 1'b0) @(posedge hclk);
    while (led_pwm[0] !== 1'b1) @(posedge hclk);
    while (led_pwm[0] === 1'b1)
    begin
      @(posedge hclk);
      hi++;
    end
  endtask : width
  task automatic end_of_test;
    $display("errors %0d checks %0d", n_errors, n_tests);
    if (n_errors == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : end_of_test
  initial
  begin
    hclk = 1'b0;
    forever #2 hclk = ~hclk;
  end
  initial
  begin
    #400000;
    n_errors++;
    end_of_test();
  end
  initial
  begin
    hresetn = 1'b0;
    ce = 1'b1;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hwdata = 32'h0;
    run = 1'b0;
    high_cyc = 16'h0200;
    rows = '{'{1'b0, 8'h00, 32'h0, 32'h6216}, '{1'b0, 8'h04, 32'h0, 32'h0}, '{1'b0, 8'h0c, 32'h0, 32'h0},
      '{1'b0, 8'h10, 32'h0, 32'h0}, '{1'b1, 8'h04, 32'hffffffff, 32'hffff}, '{1'b1, 8'h0c, 32'h1234, 32'h0},
      '{1'b1, 8'h10, 32'hffff, 32'h0}, '{1'b1, 8'h00, 32'h6e80, 32'h6e80}, '{1'b1, 8'h00, 32'h6e01, 32'h6e01},
      '{1'b1, 8'h04, 32'h8000, 32'h8000}};
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    foreach (rows[i])
    begin
      if (rows[i].wr)
        bus(1'b1, rows[i].a, rows[i].d);
      bus(1'b0, rows[i].a, 32'h0);
      check(rd, rows[i].e, "register");
    end
    bus(1'b0, 8'h08, 32'h0);
    check(rd, 32'h80008000, "bypassed slope");
    // Half scale at 1024 ticks of 12.5 clocks is 6400 clocks high.
    width();
    check({31'h0, hi >= 6398 && hi <= 6402}, 32'h1, "half width");
    bus(1'b1, 8'h04, 32'h00c0);
    width();
    check({31'h0, hi >= 48 && hi <= 52}, 32'h1, "minimum pulse");
    bus(1'b1, 8'h00, 32'h6e05);
    bus(1'b1, 8'h04, 32'h00c2);
    bus(1'b0, 8'h08, 32'h0);
    check(rd, 32'h00c200c0, "slope start");
    bus(1'b1, 8'h00, 32'h6e00);
    run <= 1'b1;
    for (int k = 0; k < 3; k++)
    begin
      high_cyc <= 16'h0200 + 16'(k);
      repeat (3100) @(posedge hclk);
      bus(1'b0, 8'h0c, 32'h0);
      check(rd, (k == 2) ? 32'h8080 : 32'h8000, "held duty");
    end
    bus(1'b1, 8'h00, 32'hbe00);
    // A pulse already under way may end before the mode switch shows, so start from a fresh rising edge.
    while (pwm_in !== 1'b0) @(posedge hclk);
    while (pwm_in !== 1'b1) @(posedge hclk);
    repeat (2) @(posedge hclk);
    check({26'h0, led_pwm}, 32'h07, "direct high");
    while (pwm_in !== 1'b0) @(posedge hclk);
    repeat (2) @(posedge hclk);
    check({26'h0, led_pwm}, 32'h00, "direct low");
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    bus(1'b0, 8'h00, 32'h0);
    check(rd, 32'h6216, "control after reset");
    ce <= 1'b0;
    bus(1'b1, 8'h04, 32'h1234);
    ce <= 1'b1;
    bus(1'b0, 8'h04, 32'h0);
    check(rd, 32'h0, "write while frozen");
    end_of_test();
  end
endmodule : bbp_brightness_pwm_tb
`default_nettype wire

//--- tb/bbp_pwm_host.sv
// Host model that drives the brightness input pin.
`timescale 1ns/1ps
`default_nettype none
module bbp_pwm_host (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Waveform request
  input wire logic run,
  input wire logic [15:0] high_cyc,
  input wire logic [15:0] per_cyc,
  // Pin
  output logic pwm_in
);
  logic [15:0] cnt;
  logic [15:0] hi_q;
  // A new width waits for the period start, so no measured period is torn.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      cnt <= 16'h0;
      hi_q <= 16'h0;
      pwm_in <= 1'b0;
    end
    else
    begin
      cnt <= (cnt + 16'h1 >= per_cyc) ? 16'h0 : cnt + 16'h1;
      if (cnt == 16'h0)
        hi_q <= high_cyc;
      pwm_in <= run && (((cnt == 16'h0) ? high_cyc : hi_q) > cnt);
    end
  end
endmodule : bbp_pwm_host
`default_nettype wire
